// File: store_subtract_pkg.sv
// Purpose: Shared types and constants for the store/subtract decoder slice
// Assumes: Byte counts are 4 bits wide, cycle counts 10 bits wide
// Notes:   Lengths are the register-destination figures; extension bytes add on
`default_nettype none

package store_subtract_pkg;

	typedef enum logic [3:0] {
		CLS_CTRL_STORE_XFER,
		CLS_CTRL_STORE_PTR,
		CLS_CONTEXT_STORE,
		CLS_STORE_NONZERO,
		CLS_STORE_ZERO,
		CLS_SELECT_ZERO,
		CLS_SUB_IMM,
		CLS_SUB_LONG_IMM,
		CLS_SUB_SHORT,
		CLS_SUB_GEN
	} instr_class_t;

	typedef enum logic [3:0] {
		MODE_REG, MODE_AREG, MODE_IND, MODE_DSP8_AN, MODE_DSP8_BASE, MODE_DSP16_AN,
		MODE_DSP16_BASE, MODE_DSP24_AN, MODE_ABS16, MODE_ABS24, MODE_NONE
	} opmode_t;

	typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_LONG} opsize_t;

	typedef enum logic [3:0] {
		CREG_NONE, CREG_XFER_COUNT_A, CREG_XFER_COUNT_B, CREG_FLAG_REGISTER, CREG_SAVED_FLAGS,
		CREG_RELOAD_COUNT_A, CREG_RELOAD_COUNT_B, CREG_XFER_MODE_A, CREG_XFER_MODE_B,
		CREG_INT_TABLE_BASE, CREG_STACK_POINTER, CREG_STATIC_BASE, CREG_FRAME_BASE,
		CREG_SAVED_PC, CREG_VECTOR_REG, CREG_INTERRUPT_STACK_PTR
	} ctrl_reg_t;

	localparam logic [7:0] PFX_DST_IND  = 8'h09;
	localparam logic [7:0] PFX_SRC_IND  = 8'h41;
	localparam logic [7:0] PFX_BOTH_IND = 8'h49;

	localparam logic [1:0] EXT_NONE = 2'h0;
	localparam logic [1:0] EXT_8    = 2'h1;
	localparam logic [1:0] EXT_16   = 2'h2;
	localparam logic [1:0] EXT_24   = 2'h3;

	localparam logic [3:0] LEN_CTRL_XFER  = 4'h3;
	localparam logic [3:0] LEN_CTRL_PTR   = 4'h2;
	localparam logic [3:0] LEN_CONTEXT    = 4'h7;
	localparam logic [3:0] LEN_STORE_COND = 4'h3;
	localparam logic [3:0] LEN_SELECT     = 4'h4;
	localparam logic [3:0] LEN_SUB_IMM    = 4'h3;
	localparam logic [3:0] LEN_SUB_LONG   = 4'h6;
	localparam logic [3:0] LEN_SUB_SHORT  = 4'h2;
	localparam logic [3:0] LEN_SUB_GEN    = 4'h2;
	localparam logic [3:0] LEN_PREFIX     = 4'h1;
	localparam logic [3:0] LEN_WORD_IMM   = 4'h1;
	localparam logic [3:0] LEN_WORD_IMM2  = 4'h2;

	localparam logic [9:0] CYC_CTRL_XFER    = 10'h002;
	localparam logic [9:0] CYC_CTRL_PTR     = 10'h003;
	localparam logic [9:0] CYC_CONTEXT      = 10'h00A;
	localparam logic [9:0] CYC_STORE_COND   = 10'h002;
	localparam logic [9:0] CYC_ZERO_CLEAR   = 10'h001;
	localparam logic [9:0] CYC_SELECT       = 10'h003;
	localparam logic [9:0] CYC_SUB_REG      = 10'h001;
	localparam logic [9:0] CYC_SUB_MEM      = 10'h003;
	localparam logic [9:0] CYC_SUB_LONG_REG = 10'h002;
	localparam logic [9:0] CYC_SUB_LONG_MEM = 10'h004;
	localparam logic [9:0] CYC_SUB_BOTH_MEM = 10'h004;
	localparam logic [9:0] CYC_IND_ONE      = 10'h003;
	localparam logic [9:0] CYC_IND_BOTH     = 10'h006;

	localparam logic [2:0] CREG_UNASSIGNED_CODE = 3'h6;
	localparam logic [1:0] RST_SYNC_INIT        = 2'h0;

endpackage : store_subtract_pkg

`default_nettype wire

// File: operand_field_decode.sv
// Purpose: Decode one five-bit general operand field
// Assumes: Pure combinational, used for both source and destination
// Notes:   Codes 1010x to 1111x are not assigned and raise bad
`default_nettype none

module operand_field_decode (
	input  wire logic [4:0]                  field,
	output var  store_subtract_pkg::opmode_t mode,
	output logic      [1:0]                  sel,
	output logic      [1:0]                  ext,
	output logic                             is_mem,
	output logic                             bad
);

	always_comb begin
		mode = store_subtract_pkg::MODE_NONE;
		sel  = {1'b0, field[0]};
		ext  = store_subtract_pkg::EXT_NONE;
		bad  = 1'b0;
		unique casez (field)
			5'b1001?: mode = store_subtract_pkg::MODE_REG;
			5'b1000?: begin
				mode = store_subtract_pkg::MODE_REG;
				sel  = {1'b1, field[0]};
			end
			5'b0001?: mode = store_subtract_pkg::MODE_AREG;
			5'b0000?: mode = store_subtract_pkg::MODE_IND;
			5'b0010?: begin
				mode = store_subtract_pkg::MODE_DSP8_AN;
				ext  = store_subtract_pkg::EXT_8;
			end
			5'b0011?: begin
				mode = store_subtract_pkg::MODE_DSP8_BASE;
				ext  = store_subtract_pkg::EXT_8;
			end
			5'b0100?: begin
				mode = store_subtract_pkg::MODE_DSP16_AN;
				ext  = store_subtract_pkg::EXT_16;
			end
			5'b0101?: begin
				mode = store_subtract_pkg::MODE_DSP16_BASE;
				ext  = store_subtract_pkg::EXT_16;
			end
			5'b0110?: begin
				mode = store_subtract_pkg::MODE_DSP24_AN;
				ext  = store_subtract_pkg::EXT_24;
			end
			5'b01111: begin
				mode = store_subtract_pkg::MODE_ABS16;
				ext  = store_subtract_pkg::EXT_16;
			end
			5'b01110: begin
				mode = store_subtract_pkg::MODE_ABS24;
				ext  = store_subtract_pkg::EXT_24;
			end
			default: bad = 1'b1;
		endcase
		is_mem = (mode != store_subtract_pkg::MODE_REG) && (mode != store_subtract_pkg::MODE_AREG) && !bad;
	end

endmodule : operand_field_decode

`default_nettype wire

// File: store_subtract_opcode_decoder.sv
// Purpose: Operand selects, length and cycle accounting for store and subtract
// Assumes: Fetch splits prefix, class and fields; inputs come from mclk logic
// Notes:   One request per enabled cycle, answer registered one edge later
`default_nettype none

module store_subtract_opcode_decoder (
	input  wire logic                             mclk,
	input  wire logic                             reset_n,
	input  wire logic                             ce,
	input  wire logic                             req_valid,
	input  wire store_subtract_pkg::instr_class_t req_class,
	input  wire logic                             prefix_present,
	input  wire logic      [7:0]                  prefix_byte,
	input  wire logic                             size_word,
	input  wire logic      [4:0]                  src_field,
	input  wire logic      [4:0]                  dst_field,
	input  wire logic      [1:0]                  short_dst,
	input  wire logic      [2:0]                  ctrl_src,
	input  wire logic                             zero_flag,
	input  wire logic      [7:0]                  xfer_count,
	output logic                                  dec_valid,
	output logic                                  dec_illegal,
	output logic      [3:0]                       instr_len,
	output logic      [9:0]                       exec_cycles,
	output logic                                  src_indirect,
	output logic                                  dst_indirect,
	output var  store_subtract_pkg::opmode_t      src_mode,
	output logic      [1:0]                       src_sel,
	output var  store_subtract_pkg::opmode_t      dst_mode,
	output logic      [1:0]                       dst_sel,
	output var  store_subtract_pkg::opsize_t      op_size,
	output var  store_subtract_pkg::ctrl_reg_t    ctrl_sel,
	output logic                                  dest_write
);

	logic [1:0] rst_sync_q;
	logic       rst_n;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_q <= store_subtract_pkg::RST_SYNC_INIT;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	store_subtract_pkg::opmode_t g_mode;
	store_subtract_pkg::opmode_t s_mode;
	logic [1:0] g_sel, g_ext, s_sel, s_ext;
	logic       g_mem, g_bad, s_mem, s_bad;

	operand_field_decode u_dst (
		.field  (dst_field),
		.mode   (g_mode),
		.sel    (g_sel),
		.ext    (g_ext),
		.is_mem (g_mem),
		.bad    (g_bad)
	);

	operand_field_decode u_src (
		.field  (src_field),
		.mode   (s_mode),
		.sel    (s_sel),
		.ext    (s_ext),
		.is_mem (s_mem),
		.bad    (s_bad)
	);

	logic                          valid_q, valid_d;
	logic                          bad_q, bad_d;
	logic [3:0]                    len_q, len_d;
	logic [9:0]                    cyc_q, cyc_d;
	logic                          sind_q, sind_d, dind_q, dind_d;
	store_subtract_pkg::opmode_t   smode_q, smode_d, dmode_q, dmode_d;
	logic [1:0]                    ssel_q, ssel_d, dsel_q, dsel_d;
	store_subtract_pkg::opsize_t   size_q, size_d;
	store_subtract_pkg::ctrl_reg_t creg_q, creg_d;
	logic                          wr_q, wr_d;
	logic                          pfx_bad, pfx_ok, dmem;
	logic [1:0]                    dext;
	logic [3:0]                    wbyte;

	always_comb begin
		valid_d = req_valid;
		bad_d   = bad_q;
		len_d   = len_q;
		cyc_d   = cyc_q;
		sind_d  = sind_q;
		dind_d  = dind_q;
		smode_d = smode_q;
		ssel_d  = ssel_q;
		dmode_d = dmode_q;
		dsel_d  = dsel_q;
		size_d  = size_q;
		creg_d  = creg_q;
		wr_d    = wr_q;
		pfx_bad = 1'b0;
		dmem    = g_mem;
		dext    = g_ext;
		wbyte   = {3'h0, size_word};
		pfx_ok  = (req_class != store_subtract_pkg::CLS_CTRL_STORE_XFER)
			&& (req_class != store_subtract_pkg::CLS_CTRL_STORE_PTR)
			&& (req_class != store_subtract_pkg::CLS_CONTEXT_STORE);
		if (req_valid) begin
			sind_d = 1'b0;
			dind_d = 1'b0;
			if (prefix_present) begin
				case (prefix_byte)
					store_subtract_pkg::PFX_DST_IND: dind_d = 1'b1;
					store_subtract_pkg::PFX_SRC_IND: sind_d = 1'b1;
					store_subtract_pkg::PFX_BOTH_IND: begin
						sind_d = 1'b1;
						dind_d = 1'b1;
					end
					default: pfx_bad = 1'b1;
				endcase
				// Source prefixes only exist on the two-operand subtract
				if (!pfx_ok || (sind_d && req_class != store_subtract_pkg::CLS_SUB_GEN)) begin
					pfx_bad = 1'b1;
					sind_d  = 1'b0;
					dind_d  = 1'b0;
				end
			end
			dmode_d = g_mode;
			dsel_d  = g_sel;
			smode_d = store_subtract_pkg::MODE_NONE;
			ssel_d  = 2'h0;
			size_d  = size_word ? store_subtract_pkg::SIZE_WORD : store_subtract_pkg::SIZE_BYTE;
			creg_d  = store_subtract_pkg::CREG_NONE;
			bad_d   = g_bad || pfx_bad;
			wr_d    = 1'b1;
			len_d   = 4'h0;
			cyc_d   = 10'h000;
			unique case (req_class)
				store_subtract_pkg::CLS_CTRL_STORE_XFER: begin
					size_d = store_subtract_pkg::SIZE_WORD;
					len_d  = store_subtract_pkg::LEN_CTRL_XFER + {2'h0, dext};
					cyc_d  = store_subtract_pkg::CYC_CTRL_XFER;
					unique case (ctrl_src)
						3'h0: creg_d = store_subtract_pkg::CREG_XFER_COUNT_A;
						3'h1: creg_d = store_subtract_pkg::CREG_XFER_COUNT_B;
						3'h2: creg_d = store_subtract_pkg::CREG_FLAG_REGISTER;
						3'h3: creg_d = store_subtract_pkg::CREG_SAVED_FLAGS;
						3'h4: creg_d = store_subtract_pkg::CREG_RELOAD_COUNT_A;
						3'h5: creg_d = store_subtract_pkg::CREG_RELOAD_COUNT_B;
						3'h6: creg_d = store_subtract_pkg::CREG_XFER_MODE_A;
						3'h7: creg_d = store_subtract_pkg::CREG_XFER_MODE_B;
					endcase
				end
				store_subtract_pkg::CLS_CTRL_STORE_PTR: begin
					size_d = store_subtract_pkg::SIZE_LONG;
					len_d  = store_subtract_pkg::LEN_CTRL_PTR + {2'h0, dext};
					cyc_d  = store_subtract_pkg::CYC_CTRL_PTR;
					// Long register column has only the two pairs
					bad_d  = bad_d || (g_mode == store_subtract_pkg::MODE_REG && g_sel[1]);
					unique case (ctrl_src)
						3'h0: creg_d = store_subtract_pkg::CREG_INT_TABLE_BASE;
						3'h1: creg_d = store_subtract_pkg::CREG_STACK_POINTER;
						3'h2: creg_d = store_subtract_pkg::CREG_STATIC_BASE;
						3'h3: creg_d = store_subtract_pkg::CREG_FRAME_BASE;
						3'h4: creg_d = store_subtract_pkg::CREG_SAVED_PC;
						3'h5: creg_d = store_subtract_pkg::CREG_VECTOR_REG;
						3'h6: creg_d = store_subtract_pkg::CREG_NONE;
						3'h7: creg_d = store_subtract_pkg::CREG_INTERRUPT_STACK_PTR;
					endcase
					if (ctrl_src == store_subtract_pkg::CREG_UNASSIGNED_CODE) begin
						bad_d = 1'b1;
					end
				end
				store_subtract_pkg::CLS_CONTEXT_STORE: begin
					size_d  = store_subtract_pkg::SIZE_LONG;
					smode_d = store_subtract_pkg::MODE_ABS16;
					dmode_d = store_subtract_pkg::MODE_ABS24;
					dsel_d  = 2'h0;
					bad_d   = pfx_bad;
					len_d   = store_subtract_pkg::LEN_CONTEXT;
					cyc_d   = store_subtract_pkg::CYC_CONTEXT + {1'b0, xfer_count, 1'b0};
				end
				store_subtract_pkg::CLS_STORE_NONZERO, store_subtract_pkg::CLS_STORE_ZERO: begin
					len_d = store_subtract_pkg::LEN_STORE_COND + {2'h0, dext} + wbyte;
					cyc_d = store_subtract_pkg::CYC_STORE_COND;
					if (req_class == store_subtract_pkg::CLS_STORE_ZERO) begin
						wr_d = zero_flag;
						if (!zero_flag) begin
							cyc_d = cyc_d + store_subtract_pkg::CYC_ZERO_CLEAR;
						end
					end else begin
						wr_d = !zero_flag;
					end
				end
				store_subtract_pkg::CLS_SELECT_ZERO: begin
					len_d = store_subtract_pkg::LEN_SELECT + {2'h0, dext}
						+ (size_word ? store_subtract_pkg::LEN_WORD_IMM2 : 4'h0);
					cyc_d = store_subtract_pkg::CYC_SELECT;
				end
				store_subtract_pkg::CLS_SUB_IMM: begin
					len_d = store_subtract_pkg::LEN_SUB_IMM + {2'h0, dext} + wbyte;
					cyc_d = dmem ? store_subtract_pkg::CYC_SUB_MEM : store_subtract_pkg::CYC_SUB_REG;
				end
				store_subtract_pkg::CLS_SUB_LONG_IMM: begin
					size_d = store_subtract_pkg::SIZE_LONG;
					bad_d  = bad_d || (g_mode == store_subtract_pkg::MODE_REG && g_sel[1]);
					len_d  = store_subtract_pkg::LEN_SUB_LONG + {2'h0, dext};
					cyc_d  = dmem ? store_subtract_pkg::CYC_SUB_LONG_MEM : store_subtract_pkg::CYC_SUB_LONG_REG;
				end
				store_subtract_pkg::CLS_SUB_SHORT: begin
					bad_d = pfx_bad;
					dsel_d = {1'b0, short_dst[0]};
					unique case (short_dst)
						2'h0: begin
							dmode_d = store_subtract_pkg::MODE_REG;
							dext    = store_subtract_pkg::EXT_NONE;
						end
						2'h1: begin
							dmode_d = store_subtract_pkg::MODE_ABS16;
							dsel_d  = 2'h0;
							dext    = store_subtract_pkg::EXT_16;
						end
						2'h2, 2'h3: begin
							dmode_d = store_subtract_pkg::MODE_DSP8_BASE;
							dext    = store_subtract_pkg::EXT_8;
						end
					endcase
					dmem  = (short_dst != 2'h0);
					len_d = store_subtract_pkg::LEN_SUB_SHORT + {2'h0, dext} + wbyte;
					cyc_d = dmem ? store_subtract_pkg::CYC_SUB_MEM : store_subtract_pkg::CYC_SUB_REG;
				end
				store_subtract_pkg::CLS_SUB_GEN: begin
					smode_d = s_mode;
					ssel_d  = s_sel;
					bad_d   = bad_d || s_bad;
					len_d   = store_subtract_pkg::LEN_SUB_GEN + {2'h0, s_ext} + {2'h0, dext};
					if (s_mem && dmem) begin
						cyc_d = store_subtract_pkg::CYC_SUB_BOTH_MEM;
					end else if (s_mem || dmem) begin
						cyc_d = store_subtract_pkg::CYC_SUB_MEM;
					end else begin
						cyc_d = store_subtract_pkg::CYC_SUB_REG;
					end
				end
				default: bad_d = 1'b1;
			endcase
			if (sind_d || dind_d) begin
				len_d = len_d + store_subtract_pkg::LEN_PREFIX;
			end
			if (sind_d && dind_d) begin
				cyc_d = cyc_d + store_subtract_pkg::CYC_IND_BOTH;
			end else if (sind_d || dind_d) begin
				cyc_d = cyc_d + store_subtract_pkg::CYC_IND_ONE;
			end
			if (bad_d) begin
				wr_d = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			valid_q <= 1'b0;
			bad_q   <= 1'b0;
			len_q   <= 4'h0;
			cyc_q   <= 10'h000;
			sind_q  <= 1'b0;
			dind_q  <= 1'b0;
			smode_q <= store_subtract_pkg::MODE_NONE;
			ssel_q  <= 2'h0;
			dmode_q <= store_subtract_pkg::MODE_NONE;
			dsel_q  <= 2'h0;
			size_q  <= store_subtract_pkg::SIZE_BYTE;
			creg_q  <= store_subtract_pkg::CREG_NONE;
			wr_q    <= 1'b0;
		end else if (ce) begin
			valid_q <= valid_d;
			bad_q   <= bad_d;
			len_q   <= len_d;
			cyc_q   <= cyc_d;
			sind_q  <= sind_d;
			dind_q  <= dind_d;
			smode_q <= smode_d;
			ssel_q  <= ssel_d;
			dmode_q <= dmode_d;
			dsel_q  <= dsel_d;
			size_q  <= size_d;
			creg_q  <= creg_d;
			wr_q    <= wr_d;
		end
	end

	assign dec_valid    = valid_q;
	assign dec_illegal  = bad_q;
	assign instr_len    = len_q;
	assign exec_cycles  = cyc_q;
	assign src_indirect = sind_q;
	assign dst_indirect = dind_q;
	assign src_mode     = smode_q;
	assign src_sel      = ssel_q;
	assign dst_mode     = dmode_q;
	assign dst_sel      = dsel_q;
	assign op_size      = size_q;
	assign ctrl_sel     = creg_q;
	assign dest_write   = wr_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_req(store_subtract_pkg::instr_class_t c);
		ce && req_valid && req_class == c;
	endsequence
	sequence s_pfx(logic [7:0] p);
		prefix_present && prefix_byte == p;
	endsequence
	sequence s_plain_reg_dst;
		!prefix_present && dst_field == 5'b10010 && !size_word;
	endsequence

	AST_DST_PREFIX: assert property (s_req(store_subtract_pkg::CLS_STORE_NONZERO) and s_pfx(8'h09)
		|=> dec_valid && dst_indirect && !src_indirect) else $error("dest prefix not decoded");
	AST_SRC_PREFIX: assert property (s_req(store_subtract_pkg::CLS_SUB_GEN) and s_pfx(8'h41)
		|=> src_indirect && !dst_indirect) else $error("source prefix not decoded");
	AST_BOTH_PREFIX: assert property (s_req(store_subtract_pkg::CLS_SUB_GEN) and s_pfx(8'h49)
		|=> src_indirect && dst_indirect) else $error("both prefix not decoded");
	AST_IND_ONE: assert property (s_req(store_subtract_pkg::CLS_STORE_NONZERO) and s_pfx(8'h09)
		and dst_field == 5'b10010 && !size_word |=> instr_len == 4'h4 && exec_cycles == 10'h005)
		else $error("single indirect cost wrong");
	AST_IND_BOTH: assert property (s_req(store_subtract_pkg::CLS_SUB_GEN) and s_pfx(8'h49)
		and src_field == 5'b10010 && dst_field == 5'b10010 |=> instr_len == 4'h3 && exec_cycles == 10'h007)
		else $error("double indirect cost wrong");
	AST_ZERO_CLEAR: assert property (s_req(store_subtract_pkg::CLS_STORE_ZERO) and s_plain_reg_dst
		|=> exec_cycles == ($past(zero_flag) ? 10'h002 : 10'h003) && dest_write == $past(zero_flag))
		else $error("store on zero timing wrong");
	AST_SELECT_WORD: assert property (s_req(store_subtract_pkg::CLS_SELECT_ZERO) and !prefix_present
		and dst_field == 5'b01110 && size_word |=> instr_len == 4'h9 && exec_cycles == 10'h003)
		else $error("select store word length wrong");
	AST_CONTEXT: assert property (s_req(store_subtract_pkg::CLS_CONTEXT_STORE)
		|=> instr_len == 4'h7 && exec_cycles == 10'd10 + 10'd2 * {2'h0, $past(xfer_count)})
		else $error("context store accounting wrong");
	AST_UNASSIGNED: assert property (s_req(store_subtract_pkg::CLS_CTRL_STORE_PTR) and ctrl_src == 3'h6
		|=> !dest_write && dec_illegal && ctrl_sel == store_subtract_pkg::CREG_NONE)
		else $error("unassigned control source wrote");
	AST_MEM_SRC: assert property (s_req(store_subtract_pkg::CLS_SUB_GEN) and !prefix_present
		and src_field == 5'b00000 && dst_field == 5'b00000 |=> exec_cycles == 10'h004 && instr_len == 4'h2)
		else $error("memory source subtract wrong");
	AST_FREEZE: assert property (!ce ##1 !ce |-> $stable(dec_valid) && $stable(exec_cycles))
		else $error("state moved while disabled");

endmodule : store_subtract_opcode_decoder

`default_nettype wire

// File: fetch_model.sv
// Purpose: Fetch-side model presenting one decode request per cycle
// Assumes: Bench packs each request into one word
// Notes:   Copied on the falling edge so the decoder samples settled inputs
`default_nettype none

module fetch_model (
	input  wire logic                             mclk,
	input  wire logic      [39:0]                 slot,
	output logic                                  ce,
	output logic                                  req_valid,
	output var  store_subtract_pkg::instr_class_t req_class,
	output logic                                  prefix_present,
	output logic      [7:0]                       prefix_byte,
	output logic                                  size_word,
	output logic      [4:0]                       src_field,
	output logic      [4:0]                       dst_field,
	output logic      [1:0]                       short_dst,
	output logic      [2:0]                       ctrl_src,
	output logic                                  zero_flag,
	output logic      [7:0]                       xfer_count
);
	timeunit 1ns;
	timeprecision 1ps;
	// Starts at zero so the decoder never sees unknown inputs
	logic [39:0] hold_q = '0;
	always @(negedge mclk) hold_q <= slot;
	assign {ce, req_valid} = hold_q[39:38];
	assign req_class = store_subtract_pkg::instr_class_t'(hold_q[37:34]);
	assign {prefix_present, prefix_byte, size_word, src_field, dst_field, short_dst, ctrl_src, zero_flag,
		xfer_count} = hold_q[33:0];
endmodule : fetch_model

`default_nettype wire

// File: tb_top.sv
// Purpose: Self-checking bench for the store/subtract decoder
// Assumes: Fetch model launches requests at the falling edge
// Notes:   Model recomputes length and cycles from the field codes
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic ce, v; logic [3:0] cls; logic pp; logic [7:0] pb; logic sw;
		logic [4:0] src, dst; logic [1:0] sd; logic [2:0] cs; logic z; logic [7:0] xc;
	} req_t;
	req_t r;
	logic mclk, reset_n, ce, req_valid, prefix_present, size_word, zero_flag;
	logic dec_valid, dec_illegal, src_indirect, dst_indirect, dest_write;
	logic [7:0] prefix_byte, xfer_count;
	logic [4:0] src_field, dst_field;
	logic [3:0] instr_len;
	logic [9:0] exec_cycles;
	logic [2:0] ctrl_src;
	logic [1:0] short_dst, src_sel, dst_sel;
	store_subtract_pkg::instr_class_t req_class;
	store_subtract_pkg::opmode_t src_mode, dst_mode;
	store_subtract_pkg::opsize_t op_size;
	store_subtract_pkg::ctrl_reg_t ctrl_sel;
	int n_fail, checked, cyc, e_v, e_ill, e_len, e_cyc, e_ps, e_pd, e_wr, e_mode, e_size, e_creg, e_cls, e_any;
	int e_sm, e_ss, e_ds;
	int blen[16] = '{3, 2, 7, 3, 3, 4, 3, 6, 2, 2, 0, 0, 0, 0, 0, 0};
	int bcyc[16] = '{2, 3, 0, 2, 2, 3, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
	logic [7:0] pfx[3] = '{8'h09, 8'h41, 8'h49};

	fetch_model fetch_model_inst (.mclk, .slot(r), .ce, .req_valid, .req_class, .prefix_present, .prefix_byte,
		.size_word, .src_field, .dst_field, .short_dst, .ctrl_src, .zero_flag, .xfer_count);
	store_subtract_opcode_decoder store_subtract_opcode_decoder_inst (.mclk, .reset_n, .ce, .req_valid, .req_class,
		.prefix_present, .prefix_byte, .size_word, .src_field, .dst_field, .short_dst, .ctrl_src, .zero_flag,
		.xfer_count, .dec_valid, .dec_illegal, .instr_len, .exec_cycles, .src_indirect, .dst_indirect,
		.src_mode, .src_sel, .dst_mode, .dst_sel, .op_size, .ctrl_sel, .dest_write);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	function automatic int ext(input logic [4:0] f);
		if (f[4:1] == 4'h7) return f[0] ? 2 : 3;
		return f[4] ? 0 : f[3:2];
	endfunction : ext

	function automatic int md(input logic [4:0] f);
		if (f[4]) return 0;
		if (f[3:1] == 3'h7) return f[0] ? 8 : 9;
		return f[3:1] == 0 ? 2 : f[3:1] == 1 ? 1 : f[3:1] + 1;
	endfunction : md

	// Register index for the four data registers, bit0 picks the pair member otherwise
	function automatic int sl(input logic [4:0] f);
		return (f[4:1] == 4'h8 ? 2 : 0) + f[0];
	endfunction : sl

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic predict();
		int e, md_, ms;
		e_v = r.ce ? r.v : e_v;
		if (!(r.ce && r.v)) return;
		e = ext(r.dst);
		md_ = !r.dst[4] && r.dst[3:1] != 3'h1;
		ms = !r.src[4] && r.src[3:1] != 3'h1;
		e_cls = r.cls;
		e_any = 1;
		e_ps = r.pp && r.cls == 9 && (r.pb == 8'h41 || r.pb == 8'h49);
		e_pd = r.pp && ((r.pb == 8'h09 && r.cls > 2) || (e_ps && r.pb[3]));
		e_ill = r.cls > 9 || (r.cls != 2 && r.cls != 8 && r.dst > 19) || (r.cls == 9 && r.src > 19);
		e_ill |= (r.pp && !e_pd && !e_ps) || (r.cls == 1 && (r.cs == 6 || r.dst[4:1] == 4'h8));
		e_ill |= r.cls == 7 && r.dst[4:1] == 4'h8;
		e_len = blen[r.cls] + (r.cls == 2 || r.cls == 8 ? 0 : e) + (r.cls == 9 ? ext(r.src) : 0)
			+ (r.cls inside {3, 4, 6, 8} ? r.sw : r.cls == 5 ? 2 * r.sw : 0) + (r.cls == 8 ? (r.sd == 1 ? 2 : r.sd[1]) : 0);
		e_cyc = r.cls == 2 ? 10 + 2 * r.xc : r.cls == 6 ? (md_ ? 3 : 1) : r.cls == 7 ? (md_ ? 4 : 2)
			: r.cls == 8 ? (r.sd == 0 ? 1 : 3) : r.cls == 9 ? (ms ? 3 : 1) + (md_ ? (ms ? 1 : 2) : 0)
			: bcyc[r.cls] + (r.cls == 4 && !r.z);
		if (e_ps || e_pd) begin
			e_len++;
			e_cyc += e_ps && e_pd ? 6 : 3;
		end
		e_wr = e_ill ? 0 : r.cls == 3 ? !r.z : r.cls == 4 ? r.z : 1;
		e_size = r.cls == 0 ? 1 : r.cls inside {1, 7} ? 2 : r.sw;
		e_mode = r.cls == 2 ? 9 : r.cls == 8 ? (r.sd == 0 ? 0 : r.sd == 1 ? 8 : 4) : md(r.dst);
		e_creg = r.cls == 0 ? 1 + r.cs : r.cs == 7 ? 15 : 9 + r.cs;
		e_sm = r.cls == 9 ? md(r.src) : r.cls == 2 ? 8 : 10;
		e_ss = r.cls == 9 ? sl(r.src) : 0;
		e_ds = r.cls == 2 ? 0 : r.cls == 8 ? r.sd == 3 : sl(r.dst);
	endtask : predict

	task automatic go();
		predict();
		@(negedge mclk);
		@(posedge mclk);
		#1;
		chk(dec_valid, e_v);
		chk(dec_illegal, e_ill);
		chk(dest_write, e_wr);
		if (e_any && !e_ill) begin
			chk(instr_len, e_len);
			chk(exec_cycles, e_cyc);
			chk(src_indirect, e_ps);
			chk(dst_indirect, e_pd);
			chk(dst_mode, e_mode);
			chk(src_mode, e_sm);
			chk(src_sel, e_ss);
			chk(dst_sel, e_ds);
			if (e_cls != 2) chk(op_size, e_size);
			if (e_cls < 2) chk(ctrl_sel, e_creg);
		end
	endtask : go

	task automatic rnd(input int c);
		r = req_t'(40'({$urandom, $urandom}));
		r.ce = $urandom_range(7) != 0;
		r.v = $urandom_range(7) != 0;
		r.cls = c[3:0];
		r.pp = $urandom_range(2) == 0;
		r.pb = pfx[$urandom_range(2)];
		r.src = 5'($urandom_range(19));
		r.dst = 5'($urandom_range(19));
		go();
	endtask : rnd

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc > 20000) begin
			n_fail++;
			report_and_stop();
		end
	end

	initial begin
		reset_n = 1'b0;
		r = '0;
		void'($urandom(36));
		repeat (5) @(posedge mclk);
		@(negedge mclk);
		reset_n = 1'b1;
		repeat (2) @(posedge mclk);
		r = '{ce: 1, v: 1, cls: 9, pp: 1, pb: 8'h49, src: 5'h12, dst: 5'h12, default: 0};
		go();
		chk(exec_cycles, 7);
		r = '{ce: 1, v: 1, cls: 4, dst: 5'h12, default: 0};
		go();
		chk(exec_cycles, 3);
		for (int k = 0; k < 16; k++) begin
			r = '{ce: 1, v: 1, cls: k / 8, cs: k % 8, dst: 5'h12, default: 0};
			go();
		end
		r = '{ce: 1, v: 1, cls: 6, pp: 1, pb: 8'h00, dst: 5'h12, default: 0};
		go();
		r.pp = 1'b0;
		r.dst = 5'h1F;
		go();
		r = '{ce: 1, v: 1, cls: 3, pp: 1, pb: 8'h09, dst: 5'h12, default: 0};
		go();
		chk(exec_cycles, 5);
		r = '{ce: 1, v: 1, cls: 5, sw: 1, dst: 5'h0E, default: 0};
		go();
		chk(instr_len, 9);
		r = '{ce: 1, v: 1, cls: 9, default: 0};
		go();
		chk(exec_cycles, 4);
		// Mid-run reset: outputs clear at once, first request on third edge after release
		@(negedge mclk);
		reset_n = 1'b0;
		@(posedge mclk);
		#1;
		chk(dec_valid, 0);
		chk(exec_cycles, 0);
		@(negedge mclk);
		reset_n = 1'b1;
		e_v = 0;
		e_ill = 0;
		e_wr = 0;
		e_any = 0;
		repeat (2) @(posedge mclk);
		for (int k = 0; k < 640; k++) rnd(k % 16);
		report_and_stop();
	end
endmodule : tb_top

`default_nettype wire
